// ===== common/csf_map.svh
// Register map, field positions, reset values and timing constants for the stack fault block
`ifndef CSF_MAP_SVH
`define CSF_MAP_SVH

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define CSF_ADDR_POSITION 12'h000
`define CSF_ADDR_STATUS 12'h004
`define CSF_ADDR_MASK 12'h008
`define CSF_ADDR_CONFIG 12'h00c
`define CSF_ADDR_SHADOW_DBG 12'h010

// ----------------------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------------------
`define CSF_POS_W 5
`define CSF_POS_RESET 5'h00
`define CSF_POS_MAX 5'h1f
`define CSF_POS_ZERO 5'h00
`define CSF_POS_ONE 5'h01
`define CSF_BIT_FULL 0
`define CSF_BIT_UNDER 1
`define CSF_BIT_FAULT_RST 0
`define CSF_EVT_W 2
`define CSF_EVT_RESET 2'h0
`define CSF_CFG_RESET 1'h0

// ----------------------------------------------------------------------------
// Bus answers
// ----------------------------------------------------------------------------
`define CSF_RESP_OKAY 2'h0
`define CSF_RESP_SLVERR 2'h2
`define CSF_WORD_ZERO 32'h0000_0000
`define CSF_BYTE_ZERO 8'h00
`define CSF_BANK_W 6
`define CSF_BANK_ZERO 6'h00

// ----------------------------------------------------------------------------
// Timing: fault reset pulse length
// ----------------------------------------------------------------------------
`define CSF_FAULT_RST_NS 40
`define CSF_CLK_NS 10
`define CSF_FAULT_RST_CYC ((`CSF_FAULT_RST_NS + `CSF_CLK_NS - 1) / `CSF_CLK_NS)

`endif

// ===== common/csf_pkg.sv
// Types shared by the stack fault block
package csf_pkg;
   // Core register set held in the shadow copy
   typedef struct packed {
      logic [7:0] status;
      logic [7:0] working;
      logic [5:0] bank;
   } csf_ctx_t;

   // Sequencer commands, one per cycle
   typedef struct packed {
      logic push;
      logic pop;
      logic fast;
      logic vector;
   } csf_cmd_t;

   // Fault reset sequencer states
   typedef enum logic [2:0] {
      CSF_IDLE = 3'b001,
      CSF_FLAG = 3'b010,
      CSF_HOLD = 3'b100
   } csf_rst_state_t;
endpackage

// ===== hw/csf_shadow.sv
// One-level shadow copy of status, working and bank-select registers
`include "csf_map.svh"

module csf_shadow (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Capture and restore
   input wire logic save,
   input wire logic restore,
   input wire csf_pkg::csf_ctx_t live,
   output csf_pkg::csf_ctx_t held,
   output logic restore_valid
);
   import csf_pkg::*;

   // ---------------------------------------------------------------------
   // Shadow storage, no bus path reaches it
   // ---------------------------------------------------------------------
   // Newest save always overwrites; no nesting kept
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         held <= '0;
      end else if (save) begin
         held <= live;
      end
   end

   // Restore strobe to the core, one cycle after the fast return
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         restore_valid <= 1'b0;
      end else begin
         restore_valid <= restore;
      end
   end

   // ---------------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------------
   a_shadow_capture: assert property (@(posedge clk) disable iff (!rstn)
      save |=> held == $past(live))
      else $error("shadow did not capture live registers");
   a_shadow_hold: assert property (@(posedge clk) disable iff (!rstn)
      !save |=> held == $past(held))
      else $error("shadow changed without a save");
endmodule

// ===== hw/csf_top.sv
// Return-address stack position, fault flags and shadow register control
//
// The implementer's own choices: the register addresses and register access over AXI4-Lite.
`include "csf_map.svh"

module csf_top (
   // Clock and power-on reset
   input wire logic CLK,
   input wire logic RSTN,
   // Core sequencer
   input wire csf_pkg::csf_cmd_t CMD,
   input wire csf_pkg::csf_ctx_t LIVE_CTX,
   output csf_pkg::csf_ctx_t RESTORE_CTX,
   output logic RESTORE_VALID,
   output logic [4:0] POSITION,
   output logic DEVICE_RESET,
   // Interrupt
   output logic IRQ,
   // AXI4-Lite write address
   input wire logic [11:0] AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   // AXI4-Lite write data
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   // AXI4-Lite write response
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   // AXI4-Lite read address
   input wire logic [11:0] ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   // AXI4-Lite read data
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY
);
   import csf_pkg::*;

   localparam int RST_CYC = `CSF_FAULT_RST_CYC;

   // ---------------------------------------------------------------------
   // State
   // ---------------------------------------------------------------------
   logic [`CSF_POS_W-1:0] pos;
   logic [`CSF_EVT_W-1:0] flags;
   logic [`CSF_EVT_W-1:0] mask;
   logic fault_rst_en;
   logic [`CSF_EVT_W-1:0] fault_evt;
   logic [`CSF_EVT_W-1:0] flag_clr;
   logic pos_wr;
   logic cfg_wr;
   logic mask_wr;
   logic [7:0] rst_cnt;
   csf_rst_state_t rst_state;
   logic aw_held;
   logic w_held;
   logic [11:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic wr_go;
   logic do_save;
   logic do_restore;
   logic sys_rstn;

   // Fault reset must not clear the sticky flags, so only the stack logic
   // sees it; flags and bus stay on power-on reset alone
   assign sys_rstn = RSTN;

   // ---------------------------------------------------------------------
   // Stack fault detection
   // ---------------------------------------------------------------------
   // Push while full or pop while empty; position saturates
   assign fault_evt[`CSF_BIT_FULL] = CMD.push && (pos == `CSF_POS_MAX);
   assign fault_evt[`CSF_BIT_UNDER] = CMD.pop && (pos == `CSF_POS_ZERO);

   // Shadow actions from the sequencer
   assign do_save = CMD.vector || (CMD.push && CMD.fast);
   assign do_restore = CMD.pop && CMD.fast;

   // Position counter; the fault reset also returns it to empty
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         pos <= `CSF_POS_RESET;
      end else if (rst_state == CSF_HOLD) begin
         pos <= `CSF_POS_RESET;
      end else if (pos_wr) begin
         pos <= w_data[`CSF_POS_W-1:0];
      end else if (CMD.push && !CMD.pop && !fault_evt[`CSF_BIT_FULL]) begin
         pos <= pos + `CSF_POS_ONE;
      end else if (CMD.pop && !CMD.push && !fault_evt[`CSF_BIT_UNDER]) begin
         pos <= pos - `CSF_POS_ONE;
      end
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         POSITION <= `CSF_POS_RESET;
      end else begin
         POSITION <= pos;
      end
   end

   // Sticky flags: set beats a simultaneous write-one clear
   always_ff @(posedge CLK or negedge sys_rstn) begin
      if (!sys_rstn) begin
         flags <= `CSF_EVT_RESET;
      end else begin
         flags <= (flags & ~flag_clr) | fault_evt;
      end
   end

   // ---------------------------------------------------------------------
   // Fault reset sequencer: flag first, then reset pulse
   // ---------------------------------------------------------------------
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         rst_state <= CSF_IDLE;
         rst_cnt <= 8'h00;
      end else begin
         case (rst_state)
            CSF_IDLE: begin
               if (fault_rst_en && (|fault_evt)) begin
                  rst_state <= CSF_FLAG;
               end
            end
            CSF_FLAG: begin
               rst_state <= CSF_HOLD;
               rst_cnt <= 8'(RST_CYC - 1);
            end
            CSF_HOLD: begin
               if (rst_cnt == 8'h00) begin
                  rst_state <= CSF_IDLE;
               end else begin
                  rst_cnt <= rst_cnt - 8'h01;
               end
            end
            default: rst_state <= CSF_IDLE;
         endcase
      end
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         DEVICE_RESET <= 1'b0;
      end else begin
         DEVICE_RESET <= (rst_state == CSF_FLAG) ||
            ((rst_state == CSF_HOLD) && (rst_cnt != 8'h00));
      end
   end

   // Interrupt from unmasked sticky flags
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         IRQ <= 1'b0;
      end else begin
         IRQ <= |(flags & mask);
      end
   end

   // ---------------------------------------------------------------------
   // Shadow copy
   // ---------------------------------------------------------------------
   csf_shadow u_shadow (
      .clk(CLK),
      .rstn(RSTN),
      .save(do_save),
      .restore(do_restore),
      .live(LIVE_CTX),
      .held(RESTORE_CTX),
      .restore_valid(RESTORE_VALID)
   );

   // ---------------------------------------------------------------------
   // AXI4-Lite write side
   // ---------------------------------------------------------------------
   assign wr_go = aw_held && w_held && !BVALID;
   assign pos_wr = wr_go && (aw_addr == `CSF_ADDR_POSITION) && w_strb[0];
   assign mask_wr = wr_go && (aw_addr == `CSF_ADDR_MASK) && w_strb[0];
   assign cfg_wr = wr_go && (aw_addr == `CSF_ADDR_CONFIG) && w_strb[0];
   assign flag_clr = (wr_go && (aw_addr == `CSF_ADDR_STATUS) && w_strb[0]) ?
      w_data[`CSF_EVT_W-1:0] : `CSF_EVT_RESET;

   // Address and data accepted in either order
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 12'h000;
         w_data <= `CSF_WORD_ZERO;
         w_strb <= 4'h0;
         AWREADY <= 1'b0;
         WREADY <= 1'b0;
      end else begin
         AWREADY <= !aw_held && !AWREADY && AWVALID;
         WREADY <= !w_held && !WREADY && WVALID;
         if (AWVALID && AWREADY) begin
            aw_held <= 1'b1;
            aw_addr <= {AWADDR[11:2], 2'b00};
         end
         if (WVALID && WREADY) begin
            w_held <= 1'b1;
            w_data <= WDATA;
            w_strb <= WSTRB;
         end
         if (wr_go) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
         end
      end
   end

   // Write response and config/mask registers
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         BVALID <= 1'b0;
         BRESP <= `CSF_RESP_OKAY;
      end else if (wr_go) begin
         BVALID <= 1'b1;
         BRESP <= (aw_addr == `CSF_ADDR_POSITION || aw_addr == `CSF_ADDR_STATUS ||
            aw_addr == `CSF_ADDR_MASK || aw_addr == `CSF_ADDR_CONFIG) ?
            `CSF_RESP_OKAY : `CSF_RESP_SLVERR;
      end else if (BREADY) begin
         BVALID <= 1'b0;
      end
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         mask <= `CSF_EVT_RESET;
         fault_rst_en <= `CSF_CFG_RESET;
      end else begin
         if (mask_wr) begin
            mask <= w_data[`CSF_EVT_W-1:0];
         end
         if (cfg_wr) begin
            fault_rst_en <= w_data[`CSF_BIT_FAULT_RST];
         end
      end
   end

   // ---------------------------------------------------------------------
   // AXI4-Lite read side; shadow has no address at all
   // ---------------------------------------------------------------------
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         ARREADY <= 1'b0;
         RVALID <= 1'b0;
         RDATA <= `CSF_WORD_ZERO;
         RRESP <= `CSF_RESP_OKAY;
      end else begin
         ARREADY <= !RVALID && !ARREADY && ARVALID;
         if (ARVALID && ARREADY) begin
            RVALID <= 1'b1;
            RRESP <= `CSF_RESP_OKAY;
            if ({ARADDR[11:2], 2'b00} == `CSF_ADDR_POSITION) begin
               RDATA <= {27'h0, pos};
            end else if ({ARADDR[11:2], 2'b00} == `CSF_ADDR_STATUS) begin
               RDATA <= {30'h0, flags};
            end else if ({ARADDR[11:2], 2'b00} == `CSF_ADDR_MASK) begin
               RDATA <= {30'h0, mask};
            end else if ({ARADDR[11:2], 2'b00} == `CSF_ADDR_CONFIG) begin
               RDATA <= {31'h0, fault_rst_en};
            end else begin
               RDATA <= `CSF_WORD_ZERO;
               RRESP <= `CSF_RESP_SLVERR;
            end
         end else if (RREADY) begin
            RVALID <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------------
   a_full_flag_set: assert property (@(posedge CLK) disable iff (!RSTN)
      fault_evt[`CSF_BIT_FULL] |=> flags[`CSF_BIT_FULL])
      else $error("full flag not set after push while full");
   a_under_flag_set: assert property (@(posedge CLK) disable iff (!RSTN)
      fault_evt[`CSF_BIT_UNDER] |=> flags[`CSF_BIT_UNDER])
      else $error("underflow flag not set after pop while empty");
   a_fault_reset_on: assert property (@(posedge CLK) disable iff (!RSTN)
      (fault_rst_en && |fault_evt && rst_state == CSF_IDLE) |=> ##1 DEVICE_RESET)
      else $error("enabled fault did not raise device reset");
   a_fault_reset_off: assert property (@(posedge CLK) disable iff (!RSTN)
      (rst_state == CSF_IDLE && !(fault_rst_en && |fault_evt)) |=> ##1 !DEVICE_RESET)
      else $error("device reset without enabled fault");
   a_flags_sticky: assert property (@(posedge CLK) disable iff (!RSTN)
      (flags[0] && flag_clr[0] == 1'b0) |=> flags[0])
      else $error("full flag lost without software clear");
   a_pos_push: assert property (@(posedge CLK) disable iff (!RSTN)
      (CMD.push && !CMD.pop && !fault_evt[0] && !pos_wr && rst_state != CSF_HOLD)
      |=> pos == $past(pos) + `CSF_POS_ONE)
      else $error("position did not step up on push");
   a_pos_pop: assert property (@(posedge CLK) disable iff (!RSTN)
      (CMD.pop && !CMD.push && !fault_evt[1] && !pos_wr && rst_state != CSF_HOLD)
      |=> pos == $past(pos) - `CSF_POS_ONE)
      else $error("position did not step down on pop");
   a_fast_restore: assert property (@(posedge CLK) disable iff (!RSTN)
      do_restore |=> RESTORE_VALID)
      else $error("fast return gave no restore strobe");
endmodule

// ===== verif/csf_core_model.sv
// Core sequencer model: issues stack commands and owns the live context
module csf_core_model (
   // Clock and reset
   input wire logic CLK,
   input wire logic RSTN,
   // Stack link
   output csf_pkg::csf_cmd_t CMD,
   output csf_pkg::csf_ctx_t LIVE_CTX,
   input wire csf_pkg::csf_ctx_t RESTORE_CTX,
   input wire logic RESTORE_VALID
);
   timeunit 1ns;
   timeprecision 1ps;
   import csf_pkg::*;

   // Link state, quiet from time zero
   csf_cmd_t cmd_q = '0;
   csf_ctx_t live_q = '0;
   csf_ctx_t load_ctx = '0;
   logic load_tog = 1'b0;
   logic load_seen = 1'b0;

   assign CMD = cmd_q;
   assign LIVE_CTX = live_q;

   // Restore pulse reloads the live registers; a plain pop leaves them alone.
   // Loads arrive by toggle so only this process drives the context
   always @(posedge CLK) begin
      load_seen <= load_tog;
      if (RESTORE_VALID === 1'b1) begin
         live_q <= RESTORE_CTX;
      end else if (load_tog !== load_seen) begin
         live_q <= load_ctx;
      end
   end

   // One command pulse, then an idle edge so pulses never merge
   task automatic issue(input logic psh, input logic pp, input logic fst, input logic vec);
      @(posedge CLK);
      cmd_q <= '{push: psh, pop: pp, fast: fst, vector: vec};
      @(posedge CLK);
      cmd_q <= '0;
   endtask

   // New live context, as core instructions would leave it
   task automatic load(input csf_ctx_t c);
      @(posedge CLK);
      load_ctx <= c;
      load_tog <= ~load_tog;
   endtask
endmodule

// ===== verif/tb_top.sv
// Self-checking bench for the stack position, fault and shadow block
`include "csf_map.svh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import csf_pkg::*;

   // ------------------------------------------------------------------
   // Signals, instances, clock
   // ------------------------------------------------------------------
   localparam csf_ctx_t CTX_A = '{8'h12, 8'h34, 6'h05};
   localparam csf_ctx_t CTX_B = '{8'ha5, 8'h5a, 6'h2a};
   localparam csf_ctx_t CTX_C = '{8'h0f, 8'hf0, 6'h11};
   localparam logic [1:0] OK = `CSF_RESP_OKAY;
   localparam logic [1:0] ERR = `CSF_RESP_SLVERR;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   csf_cmd_t cmd;
   csf_ctx_t live, restore_ctx;
   logic restore_valid, device_reset, irq;
   logic [4:0] position;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0] wstrb = 4'hf;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rst_cyc = 32'h0;
   logic [31:0] rst_base = 32'h0;
   int err_count = 0;
   int checked = 0;

   always #5 clk = ~clk;

   csf_core_model core_u (.CLK(clk), .RSTN(rstn), .CMD(cmd), .LIVE_CTX(live),
      .RESTORE_CTX(restore_ctx), .RESTORE_VALID(restore_valid));

   csf_top dut_u (.CLK(clk), .RSTN(rstn), .CMD(cmd), .LIVE_CTX(live),
      .RESTORE_CTX(restore_ctx), .RESTORE_VALID(restore_valid), .POSITION(position),
      .DEVICE_RESET(device_reset), .IRQ(irq), .AWADDR(awaddr), .AWVALID(awvalid),
      .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
      .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
      .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready));

   // Counts cycles of fault reset so pulse length is checked exactly
   always @(posedge clk) begin
      if (device_reset === 1'b1) begin
         rst_cyc <= rst_cyc + 32'h1;
      end
   end

   // ------------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Both channels offered together, each released when taken
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
         n++;
      end while (bvalid !== 1'b1 && n < 200);
      chk({30'h0, bresp}, {30'h0, er});
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arready === 1'b1) arvalid <= 1'b0;
         n++;
      end while (rvalid !== 1'b1 && n < 200);
      chk(rdata, exp);
      chk({30'h0, rresp}, {30'h0, er});
      rready <= 1'b0;
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic results;
      $display("comparisons %0d, mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // Watchdog far beyond the expected run of under three hundred cycles
   initial begin
      repeat (5000) @(posedge clk);
      err_count++;
      results();
   end

   // Main sequence
   initial begin
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      rd(`CSF_ADDR_POSITION, 32'h0, OK);
      rd(`CSF_ADDR_STATUS, 32'h0, OK);
      rd(`CSF_ADDR_MASK, 32'h0, OK);
      rd(`CSF_ADDR_CONFIG, 32'h0, OK);
      rd(`CSF_ADDR_SHADOW_DBG, 32'h0, ERR);
      wr(`CSF_ADDR_SHADOW_DBG, 32'h0000_00ff, ERR);
      wr(`CSF_ADDR_POSITION, 32'hffff_ffff, OK);
      rd(`CSF_ADDR_POSITION, 32'h1f, OK);
      chk({27'h0, position}, 32'h1f);
      // Strobe without byte 0 writes nothing but still answers OKAY
      wstrb <= 4'he;
      wr(`CSF_ADDR_POSITION, 32'h0, OK);
      wstrb <= 4'hf;
      rd(`CSF_ADDR_POSITION, 32'h1f, OK);
      // Counting up and down, simultaneous push and pop holds
      wr(`CSF_ADDR_POSITION, 32'h0, OK);
      repeat (3) core_u.issue(1'b1, 1'b0, 1'b0, 1'b0);
      idle(3);
      chk({27'h0, position}, 32'h3);
      core_u.issue(1'b0, 1'b1, 1'b0, 1'b0);
      idle(3);
      chk({27'h0, position}, 32'h2);
      core_u.issue(1'b1, 1'b1, 1'b0, 1'b0);
      idle(3);
      chk({27'h0, position}, 32'h2);
      // Push when full, fault reset off: flag and interrupt only
      wr(`CSF_ADDR_MASK, 32'h1, OK);
      wr(`CSF_ADDR_POSITION, 32'h1f, OK);
      rst_base = rst_cyc;
      core_u.issue(1'b1, 1'b0, 1'b0, 1'b0);
      idle(6);
      chk(rst_cyc - rst_base, 32'h0);
      chk({27'h0, position}, 32'h1f);
      rd(`CSF_ADDR_STATUS, 32'h1, OK);
      chk({31'h0, irq}, 32'h1);
      wr(`CSF_ADDR_MASK, 32'h0, OK);
      idle(2);
      chk({31'h0, irq}, 32'h0);
      wr(`CSF_ADDR_MASK, 32'h3, OK);
      wr(`CSF_ADDR_STATUS, 32'h1, OK);
      rd(`CSF_ADDR_STATUS, 32'h0, OK);
      chk({31'h0, irq}, 32'h0);
      // Pop when empty
      wr(`CSF_ADDR_POSITION, 32'h0, OK);
      core_u.issue(1'b0, 1'b1, 1'b0, 1'b0);
      idle(3);
      rd(`CSF_ADDR_STATUS, 32'h2, OK);
      chk({31'h0, irq}, 32'h1);
      chk(rst_cyc - rst_base, 32'h0);
      wr(`CSF_ADDR_STATUS, 32'h2, OK);
      // Fault reset on: fixed pulse, flags survive it, position forced to zero
      wr(`CSF_ADDR_CONFIG, 32'h1, OK);
      wr(`CSF_ADDR_POSITION, 32'h1f, OK);
      rst_base = rst_cyc;
      core_u.issue(1'b1, 1'b0, 1'b0, 1'b0);
      idle(10);
      chk(rst_cyc - rst_base, `CSF_FAULT_RST_CYC);
      rd(`CSF_ADDR_STATUS, 32'h1, OK);
      rd(`CSF_ADDR_POSITION, 32'h0, OK);
      rst_base = rst_cyc;
      core_u.issue(1'b0, 1'b1, 1'b0, 1'b0);
      idle(10);
      chk(rst_cyc - rst_base, `CSF_FAULT_RST_CYC);
      rd(`CSF_ADDR_STATUS, 32'h3, OK);
      wr(`CSF_ADDR_CONFIG, 32'h0, OK);
      // Interrupt entry captures, fast return restores
      core_u.load(CTX_A);
      core_u.issue(1'b1, 1'b0, 1'b0, 1'b1);
      core_u.load(CTX_B);
      core_u.issue(1'b0, 1'b1, 1'b1, 1'b0);
      idle(4);
      chk({10'h0, live}, {10'h0, CTX_A});
      // Nested entry overwrites; only one fast return is taken
      core_u.issue(1'b1, 1'b0, 1'b0, 1'b1);
      core_u.load(CTX_C);
      core_u.issue(1'b1, 1'b0, 1'b0, 1'b1);
      core_u.load(CTX_A);
      core_u.issue(0, 1'b1, 1'b1, 1'b0);
      idle(4);
      chk({10'h0, live}, {10'h0, CTX_C});
      // Fast call saves; a plain return leaves live alone, a fast one restores
      core_u.load(CTX_B);
      core_u.issue(1'b1, 1'b0, 1'b1, 1'b0);
      core_u.load(CTX_A);
      core_u.issue(1'b0, 1'b1, 1'b0, 1'b0);
      idle(4);
      chk({10'h0, live}, {10'h0, CTX_A});
      core_u.issue(1'b0, 1'b1, 1'b1, 1'b0);
      idle(4);
      chk({10'h0, live}, {10'h0, CTX_B});
      // Power-on reset mid-run clears the sticky flags
      @(posedge clk);
      rstn <= 1'b0;
      idle(2);
      rstn <= 1'b1;
      rd(`CSF_ADDR_STATUS, 32'h0, OK);
      results();
   end
endmodule
